// ---- bench/pcms_host_model.sv ----
// Host-side model that issues single register accesses on the link port
`timescale 1ns/1ps
module pcms_host_model (
	input wire logic link_clk,
	output logic lk_valid,
	output logic [6:0] lk_addr,
	output logic [7:0] lk_cmd,
	output logic lk_wr,
	output logic [7:0] lk_wdata,
	input wire logic lk_ready,
	input wire logic lk_done,
	input wire logic lk_hit,
	input wire logic [7:0] lk_rdata
);
	// Idle request lines from time zero
	initial begin
		lk_valid = 1'b0;
		lk_addr = 7'h00;
		lk_cmd = 8'h00;
		lk_wr = 1'b0;
		lk_wdata = 8'h00;
	end

	// One access: hold until taken, then wait a bounded time for the answer
	task automatic xfer(input logic [6:0] a, input logic [7:0] c,
		input logic w, input logic [7:0] d, output logic h,
		output logic [7:0] q, output int lat);
		int n;
		n = 0;
		@(negedge link_clk);
		lk_valid = 1'b1;
		lk_addr = a;
		lk_cmd = c;
		lk_wr = w;
		lk_wdata = d;
		while (lk_ready !== 1'b1 && n < 20) begin
			@(negedge link_clk);
			n++;
		end
		@(posedge link_clk);
		// Released lines show the inverse so stale values never match
		@(negedge link_clk);
		lk_valid = 1'b0;
		lk_addr = ~a;
		lk_cmd = ~c;
		lk_wr = ~w;
		lk_wdata = ~d;
		lat = 0;
		while (lk_done !== 1'b1 && lat < 30) begin
			@(negedge link_clk);
			lat++;
		end
		h = lk_hit;
		q = lk_rdata;
	endtask : xfer
endmodule : pcms_host_model

// ---- bench/test_pse_channel_mode_status_regs.sv ----
// Self-checking bench for the channel mode and status register core
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
	n_fail++; $display("FAIL %s exp %h got %h", nm, exp, got); end end
module test_pse_channel_mode_status_regs;
	import pcms_pkg::*;
	logic clock = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic link_rst = 1'b1;
	logic lk_valid, lk_wr, lk_ready, lk_done, lk_hit;
	logic [6:0] lk_addr;
	logic [7:0] lk_cmd, lk_wdata, lk_rdata;
	logic [3:0] straps = 4'hA;
	logic half = 1'b1;
	logic cfg_b = 1'b0;
	logic [3:0] drain = 4'h7;
	logic [3:0] on_in = 4'hF;
	logic [3:0] det = 4'hF;
	logic [3:0] cls = 4'hF;
	logic [3:0] pon = 4'hF;
	logic [3:0] allow, det_o, cls_o, pon_o, offc, pol, gch, och, cool;
	logic [7:0] sts, mode;
	logic [3:0] s_off, s_pol, s_good, s_on, s_cool;
	logic [6:0] own;
	int n_fail = 0;
	int cmp_count = 0;
	// Mode writes in order, with the strobes and status each should give
	logic [7:0] t_w [5] = '{8'hE0, 8'h80, 8'h40, 8'h00, 8'h00};
	logic [3:0] t_off [5] = '{4'h2, 4'h4, 4'h0, 4'h8, 4'h0};
	logic [3:0] t_cool [5] = '{4'h0, 4'h4, 4'h8, 4'h0, 4'h0};
	logic [3:0] t_on [5] = '{4'h2, 4'h4, 4'h0, 4'h8, 4'h0};
	logic [3:0] t_good [5] = '{4'h2, 4'h4, 4'h0, 4'h0, 4'h0};
	logic [7:0] t_sts [5] = '{8'h4C, 8'h08, 8'h08, 8'h00, 8'h00};
	// A write answers with the mode held before it
	logic [7:0] t_old [5] = '{8'hE4, 8'hE0, 8'h80, 8'h40, 8'h00};

	// Core clock 4 ns; link clock 12 ns with an odd phase offset
	always #2 clock = ~clock;
	initial begin
		#1.3;
		forever #6 link_clk = ~link_clk;
	end

	pcms_top i_pcms_top (.clock(clock), .rst(rst), .link_clk(link_clk),
		.link_rst(link_rst), .lk_valid(lk_valid), .lk_addr(lk_addr),
		.lk_cmd(lk_cmd), .lk_wr(lk_wr), .lk_wdata(lk_wdata),
		.lk_ready(lk_ready), .lk_done(lk_done), .lk_hit(lk_hit),
		.lk_rdata(lk_rdata), .address_strap_pins(straps),
		.half_select_pin(half), .config_b_pin(cfg_b),
		.output_drain_pin(drain), .chan_on_in(on_in),
		.detect_enable_bit(det), .class_enable_bit(cls),
		.power_on_command(pon), .power_allow(allow),
		.detect_enable_out(det_o), .class_enable_out(cls_o),
		.power_on_out(pon_o), .off_clear(offc), .police_set_ones(pol),
		.good_change_event(gch), .on_change_event(och),
		.cooldown_cancel(cool), .channel_power_state(sts),
		.channel_mode_select(mode));

	pcms_host_model i_pcms_host_model (.link_clk(link_clk),
		.lk_valid(lk_valid), .lk_addr(lk_addr), .lk_cmd(lk_cmd),
		.lk_wr(lk_wr), .lk_wdata(lk_wdata), .lk_ready(lk_ready),
		.lk_done(lk_done), .lk_hit(lk_hit), .lk_rdata(lk_rdata));

	// One-cycle strobes are gathered so none is missed between checks
	always @(posedge clock) begin
		s_off <= s_off | offc;
		s_pol <= s_pol | pol;
		s_good <= s_good | gch;
		s_on <= s_on | och;
		s_cool <= s_cool | cool;
	end

	task automatic clear_seen();
		@(negedge clock);
		s_off = 4'h0;
		s_pol = 4'h0;
		s_good = 4'h0;
		s_on = 4'h0;
		s_cool = 4'h0;
	endtask : clear_seen

	// Access with expected hit and read data; a write answers the old value
	task automatic acc(input logic [6:0] a, input logic [7:0] c,
		input logic w, input logic [7:0] d, input logic eh,
		input logic [7:0] ed);
		logic h;
		logic [7:0] q;
		int lat;
		i_pcms_host_model.xfer(a, c, w, d, h, q, lat);
		`CHK("hit", eh, h)
		`CHK("rdata", ed, q)
		// Two toggle crossings plus the capture stage: about three cycles
		`CHK("latency", 1'b1, (lat >= 2 && lat <= 4))
		repeat (4) @(negedge clock);
	endtask : acc

	task automatic print_verdict();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// Hang guard well beyond the length of the sequence
	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		print_verdict();
	end

	initial begin
		clear_seen();
		repeat (12) @(negedge clock);
		rst = 1'b0;
		link_rst = 1'b0;
		repeat (6) @(negedge clock);
		own = {ADDR_PREFIX, straps, half};
		acc(own, CMD_POWER_STATE, 1'b0, 8'h00, 1'b1, 8'h00);
		acc(own, CMD_MODE, 1'b0, 8'h00, 1'b1, 8'h00);
		acc(own, CMD_STRAP, 1'b0, 8'h00, 1'b1, 8'h54);
		`CHK("allow", 4'h0, allow)
		`CHK("det_out", 4'h0, det_o)
		acc(own ^ 7'h01, CMD_STRAP, 1'b0, 8'h00, 1'b0, 8'h00);
		cfg_b = 1'b1;
		repeat (6) @(negedge clock);
		own = {ADDR_PREFIX, straps, 1'b0};
		acc(own, CMD_STRAP, 1'b0, 8'h00, 1'b1, 8'h50);
		acc(ADDR_BCAST, CMD_STRAP, 1'b0, 8'h00, 1'b1, 8'h50);
		acc(ADDR_BCAST, CMD_MODE, 1'b1, 8'hE4, 1'b1, 8'h00);
		acc(own, CMD_MODE, 1'b0, 8'h00, 1'b1, 8'hE4);
		`CHK("allow", 4'hE, allow)
		`CHK("det_out", 4'hE, det_o)
		`CHK("cls_out", 4'hE, cls_o)
		`CHK("pon_out", 4'hE, pon_o)
		acc(own, CMD_POWER_STATE, 1'b0, 8'h00, 1'b1, 8'h6E);
		// Drain back above threshold: power-good must stay latched
		drain = 4'h0;
		repeat (6) @(negedge clock);
		acc(own, CMD_POWER_STATE, 1'b1, 8'hFF, 1'b1, 8'h6E);
		acc(own, CMD_STRAP, 1'b1, 8'hFF, 1'b1, 8'h50);
		acc(own, CMD_POWER_STATE, 1'b0, 8'h00, 1'b1, 8'h6E);
		acc(own, CMD_STRAP, 1'b0, 8'h00, 1'b1, 8'h50);
		for (int i = 0; i < 5; i++) begin
			clear_seen();
			acc(own, CMD_MODE, 1'b1, t_w[i], 1'b1, t_old[i]);
			// Clears are strobes here, so no long settle is needed
			repeat (4) @(negedge clock);
			`CHK("mode", t_w[i], mode)
			`CHK("off_clear", t_off[i], s_off)
			`CHK("police", t_off[i], s_pol)
			`CHK("cooldown", t_cool[i], s_cool)
			`CHK("on_event", t_on[i], s_on)
			`CHK("good_event", t_good[i], s_good)
			`CHK("status", t_sts[i], sts)
			acc(own, CMD_POWER_STATE, 1'b0, 8'h00, 1'b1, t_sts[i]);
		end
		`CHK("allow", 4'h0, allow)
		`CHK("pon_out", 4'h0, pon_o)
		print_verdict();
	end
endmodule : test_pse_channel_mode_status_regs

// ---- design/pcms_link.sv ----
// Link-clock end: holds one register access and hands it to the core
`timescale 1ns/1ps
module pcms_link
	import pcms_pkg::*;
(
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic lk_valid,
	input wire logic [pcms_pkg::ADDRW-1:0] lk_addr,
	input wire logic [pcms_pkg::CMDW-1:0] lk_cmd,
	input wire logic lk_wr,
	input wire logic [7:0] lk_wdata,
	output logic lk_ready,
	output logic lk_done,
	output logic lk_hit,
	output logic [7:0] lk_rdata,
	pcms_xfer_if.link xif
);
	typedef enum logic {LK_IDLE, LK_WAIT} pcms_lk_state_t;

	pcms_lk_state_t state_ff, nxt_state;
	logic req_ff, nxt_req;
	logic [6:0] addr_ff, nxt_addr;
	logic [7:0] cmd_ff, nxt_cmd;
	logic wr_ff, nxt_wr;
	logic [7:0] wdata_ff, nxt_wdata;
	logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
	logic done_ff, nxt_done;
	logic hit_ff, nxt_hit;
	logic [7:0] rdata_ff, nxt_rdata;
	logic ack_edge;
	logic accept;

	// Hold registers stay put while waiting, so the core sees stable words
	assign xif.req_tgl = req_ff;
	assign xif.addr = addr_ff;
	assign xif.cmd = cmd_ff;
	assign xif.wr = wr_ff;
	assign xif.wdata = wdata_ff;
	assign lk_ready = (state_ff == LK_IDLE);
	assign lk_done = done_ff;
	assign lk_hit = hit_ff;
	assign lk_rdata = rdata_ff;

	// Acknowledge toggle synchroniser; edge taken past the second stage
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin
			ack_s1_ff <= xif.ack_tgl;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
		end
	end

	assign ack_edge = ack_s2_ff ^ ack_s3_ff;
	assign accept = lk_valid && (state_ff == LK_IDLE);

	// One access outstanding at a time; answer data is stable on ack
	always_comb begin
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_addr = addr_ff;
		nxt_cmd = cmd_ff;
		nxt_wr = wr_ff;
		nxt_wdata = wdata_ff;
		nxt_done = 1'b0;
		nxt_hit = hit_ff;
		nxt_rdata = rdata_ff;
		unique case (state_ff)
			LK_IDLE: begin
				if (lk_valid) begin
					nxt_addr = lk_addr;
					nxt_cmd = lk_cmd;
					nxt_wr = lk_wr;
					nxt_wdata = lk_wdata;
					nxt_req = ~req_ff;
					nxt_state = LK_WAIT;
				end
			end
			LK_WAIT: begin
				if (ack_edge) begin
					nxt_done = 1'b1;
					nxt_hit = xif.hit;
					nxt_rdata = xif.rdata;
					nxt_state = LK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			state_ff <= LK_IDLE;
			req_ff <= 1'b0;
			addr_ff <= 7'h00;
			cmd_ff <= 8'h00;
			wr_ff <= 1'b0;
			wdata_ff <= 8'h00;
			done_ff <= 1'b0;
			hit_ff <= 1'b0;
			rdata_ff <= RDATA_RESET;
		end else begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			addr_ff <= nxt_addr;
			cmd_ff <= nxt_cmd;
			wr_ff <= nxt_wr;
			wdata_ff <= nxt_wdata;
			done_ff <= nxt_done;
			hit_ff <= nxt_hit;
			rdata_ff <= nxt_rdata;
		end
	end

	property p_lk_toggle;
		@(posedge link_clk) disable iff (link_rst)
		accept |=> (req_ff != $past(req_ff)) && !lk_ready;
	endproperty
	a_lk_toggle: assert property (p_lk_toggle)
		else $error("link request did not toggle on accept");

	property p_lk_done_once;
		@(posedge link_clk) disable iff (link_rst)
		lk_done |-> lk_ready ##1 !lk_done;
	endproperty
	a_lk_done_once: assert property (p_lk_done_once)
		else $error("link done not a single pulse in idle");
endmodule : pcms_link

// ---- design/pcms_pkg.sv ----
// Constants, types and helpers for the channel mode and status register bank
package pcms_pkg;
	localparam int NCH = 4;
	localparam int CMDW = 8;
	localparam int ADDRW = 7;

	// Command codes of the three registers
	localparam logic [7:0] CMD_POWER_STATE = 8'h10;
	localparam logic [7:0] CMD_STRAP = 8'h11;
	localparam logic [7:0] CMD_MODE = 8'h12;

	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Field positions
	localparam int PG_LSB = 4;
	localparam int PE_LSB = 0;
	localparam int STRAP_LSB = 3;
	localparam int HALF_BIT = 2;

	// Bus address layout
	localparam logic [1:0] ADDR_PREFIX = 2'h1;
	localparam logic [6:0] ADDR_BCAST = 7'h7F;

	// Value loaded into the policing register on entry to off
	localparam logic [7:0] POLICE_OFF_VALUE = 8'hFF;

	// Time the host waits for all clears after entering off
	localparam int OFF_SETTLE_MS = 5;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_MANUAL,
		MODE_SEMI,
		MODE_AUTO
	} pcms_mode_t;

	// Mode of one channel out of the packed mode byte
	function automatic pcms_mode_t pcms_mode_of(input logic [7:0] m,
		input int ch);
		pcms_mode_of = pcms_mode_t'(m[2*ch +: 2]);
	endfunction : pcms_mode_of

	// One bit per channel that sits in off mode
	function automatic logic [NCH-1:0] pcms_off_mask(input logic [7:0] m);
		logic [NCH-1:0] r;
		r = '0;
		for (int i = 0; i < NCH; i++) begin
			r[i] = (pcms_mode_of(m, i) == MODE_OFF);
		end
		pcms_off_mask = r;
	endfunction : pcms_off_mask
endpackage : pcms_pkg

// ---- design/pcms_top.sv ----
// Channel power status, strap readback and operating mode register core
//
// Overview of operation
// - Register 10h reads power-good flags high nibble, channel-on flags low.
// - A channel turning off clears its power-good and channel-on flags.
// - Power-good sets when on and drain dropped low; latched until off.
// - Channel-on flag reads one while powered, zero while off.
// - Register 11h bits 6 to 3 show the four address strap pins.
// - Bit 2 of 11h is the half-select: 0 channels 1-4, 1 channels 5-8.
// - Configuration B forces half-select to zero; A uses the half-select pin.
// - Register 12h holds two mode bits per channel, channel 1 lowest, reset 0.
// - Mode codes: 00 off, 01 manual, 10 semiauto, 11 auto.
// - Off channels stay unpowered; detect, class and power-on ignored.
// - Entering off clears that channel's event, fault, enable and flag bits.
// - Entering off clears that channel's requested class and detect result.
// - Entering off sets that channel's policing register to all ones.
// - Entering off clears voltage, current, resistance, autoclass readings.
// - Entering off clears that channel's assigned and previous class.
// - Off clearing touches only the channel entering off.
// - A power-good or channel-on fall sets its change event bit.
// - Semiauto to manual or off cancels a running cooldown.
`timescale 1ns/1ps
module pcms_top
	import pcms_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic lk_valid,
	input wire logic [pcms_pkg::ADDRW-1:0] lk_addr,
	input wire logic [pcms_pkg::CMDW-1:0] lk_cmd,
	input wire logic lk_wr,
	input wire logic [7:0] lk_wdata,
	output logic lk_ready,
	output logic lk_done,
	output logic lk_hit,
	output logic [7:0] lk_rdata,
	input wire logic [3:0] address_strap_pins,
	input wire logic half_select_pin,
	input wire logic config_b_pin,
	input wire logic [pcms_pkg::NCH-1:0] output_drain_pin,
	input wire logic [pcms_pkg::NCH-1:0] chan_on_in,
	input wire logic [pcms_pkg::NCH-1:0] detect_enable_bit,
	input wire logic [pcms_pkg::NCH-1:0] class_enable_bit,
	input wire logic [pcms_pkg::NCH-1:0] power_on_command,
	output logic [pcms_pkg::NCH-1:0] power_allow,
	output logic [pcms_pkg::NCH-1:0] detect_enable_out,
	output logic [pcms_pkg::NCH-1:0] class_enable_out,
	output logic [pcms_pkg::NCH-1:0] power_on_out,
	output logic [pcms_pkg::NCH-1:0] off_clear,
	output logic [pcms_pkg::NCH-1:0] police_set_ones,
	output logic [pcms_pkg::NCH-1:0] good_change_event,
	output logic [pcms_pkg::NCH-1:0] on_change_event,
	output logic [pcms_pkg::NCH-1:0] cooldown_cancel,
	output logic [7:0] channel_power_state,
	output logic [7:0] channel_mode_select
);
	localparam int SYNW = 4 + 2 + NCH;

	pcms_xfer_if xif ();

	logic [SYNW-1:0] pin_s1_ff, pin_s2_ff;
	logic req_s1_ff, req_s2_ff, req_s3_ff;
	logic [3:0] strap_ff;
	logic half_ff, cfg_b_ff;
	logic [NCH-1:0] drain_low_ff;
	logic [7:0] mode_ff, nxt_mode;
	logic [NCH-1:0] pe_ff, nxt_pe, pg_ff, nxt_pg;
	logic [NCH-1:0] on_evt_ff, nxt_on_evt, good_evt_ff, nxt_good_evt;
	logic [NCH-1:0] off_clr_ff, nxt_off_clr, police_ff, nxt_police;
	logic [NCH-1:0] cool_ff, nxt_cool;
	logic [NCH-1:0] allow_ff, det_ff, cls_ff, power_on_command_ff;
	logic [NCH-1:0] nxt_allow, nxt_det, nxt_cls, nxt_power_on_command;
	logic ack_ff, nxt_ack, hit_ff, nxt_hit;
	logic [7:0] rdata_ff, nxt_rdata;
	logic req_edge, addr_hit, wr_mode;
	logic [6:0] own_addr;
	logic [NCH-1:0] off_now, entry;

	pcms_link u_link (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.lk_valid(lk_valid),
		.lk_addr(lk_addr),
		.lk_cmd(lk_cmd),
		.lk_wr(lk_wr),
		.lk_wdata(lk_wdata),
		.lk_ready(lk_ready),
		.lk_done(lk_done),
		.lk_hit(lk_hit),
		.lk_rdata(lk_rdata),
		.xif(xif.link)
	);

	// Pins and the request toggle come from other domains: two stages each
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end else begin
			pin_s1_ff <= {address_strap_pins, half_select_pin, config_b_pin,
				output_drain_pin};
			pin_s2_ff <= pin_s1_ff;
			req_s1_ff <= xif.req_tgl;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	// Field split of the synchronised pins
	assign strap_ff = pin_s2_ff[SYNW-1 -: 4];
	assign cfg_b_ff = pin_s2_ff[NCH];
	assign half_ff = pin_s2_ff[NCH+1] & ~cfg_b_ff;
	assign drain_low_ff = pin_s2_ff[NCH-1:0];

	// Access decode; request words are stable once the toggle has moved
	assign req_edge = req_s2_ff ^ req_s3_ff;
	assign own_addr = {ADDR_PREFIX, strap_ff, half_ff};
	assign addr_hit = (xif.addr == own_addr) ||
		(xif.addr == ADDR_BCAST);
	assign wr_mode = req_edge && addr_hit && xif.wr &&
		(xif.cmd == CMD_MODE);

	// Readback multiplexer over the three mapped codes
	function automatic logic [7:0] read_reg(input logic [7:0] cmd);
		logic [7:0] r;
		r = 8'h00;
		unique case (cmd)
			CMD_POWER_STATE: r = {pg_ff, pe_ff};
			CMD_STRAP: begin
				r[STRAP_LSB +: 4] = strap_ff;
				r[HALF_BIT] = half_ff;
			end
			CMD_MODE: r = mode_ff;
			default: r = 8'h00;
		endcase
		read_reg = r;
	endfunction : read_reg

	// Mode register, channel flags and the per-channel strobes
	always_comb begin
		nxt_mode = wr_mode ? xif.wdata : mode_ff;
		off_now = pcms_off_mask(nxt_mode);
		// Only channels moving from another mode into off see a strobe
		entry = off_now & ~pcms_off_mask(mode_ff);
		nxt_pe = chan_on_in & ~off_now;
		// Latch clears with the channel, so a fault turn-off drops it too
		nxt_pg = nxt_pe & (pg_ff | drain_low_ff);
		nxt_on_evt = pe_ff & ~nxt_pe;
		nxt_good_evt = pg_ff & ~nxt_pg;
		nxt_off_clr = entry;
		nxt_police = entry;
		for (int i = 0; i < NCH; i++) begin
			nxt_cool[i] = (pcms_mode_of(mode_ff, i) == MODE_SEMI) &&
				((pcms_mode_of(nxt_mode, i) == MODE_MANUAL) ||
				(pcms_mode_of(nxt_mode, i) == MODE_OFF));
		end
		nxt_allow = ~off_now;
		nxt_det = detect_enable_bit & ~off_now;
		nxt_cls = class_enable_bit & ~off_now;
		nxt_power_on_command = power_on_command & ~off_now;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_ff <= MODE_RESET;
			pe_ff <= FLAGS_RESET;
			pg_ff <= FLAGS_RESET;
			on_evt_ff <= FLAGS_RESET;
			good_evt_ff <= FLAGS_RESET;
			off_clr_ff <= FLAGS_RESET;
			police_ff <= FLAGS_RESET;
			cool_ff <= FLAGS_RESET;
			allow_ff <= FLAGS_RESET;
			det_ff <= FLAGS_RESET;
			cls_ff <= FLAGS_RESET;
			power_on_command_ff <= FLAGS_RESET;
		end else begin
			mode_ff <= nxt_mode;
			pe_ff <= nxt_pe;
			pg_ff <= nxt_pg;
			on_evt_ff <= nxt_on_evt;
			good_evt_ff <= nxt_good_evt;
			off_clr_ff <= nxt_off_clr;
			police_ff <= nxt_police;
			cool_ff <= nxt_cool;
			allow_ff <= nxt_allow;
			det_ff <= nxt_det;
			cls_ff <= nxt_cls;
			power_on_command_ff <= nxt_power_on_command;
		end
	end

	// Answer to the link; unmatched address reads zero and writes nothing
	always_comb begin
		nxt_ack = ack_ff ^ req_edge;
		nxt_hit = req_edge ? addr_hit : hit_ff;
		nxt_rdata = rdata_ff;
		if (req_edge) begin
			nxt_rdata = addr_hit ? read_reg(xif.cmd) : RDATA_RESET;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_ff <= 1'b0;
			hit_ff <= 1'b0;
			rdata_ff <= RDATA_RESET;
		end else begin
			ack_ff <= nxt_ack;
			hit_ff <= nxt_hit;
			rdata_ff <= nxt_rdata;
		end
	end

	assign xif.ack_tgl = ack_ff;
	assign xif.hit = hit_ff;
	assign xif.rdata = rdata_ff;
	assign power_allow = allow_ff;
	assign detect_enable_out = det_ff;
	assign class_enable_out = cls_ff;
	assign power_on_out = power_on_command_ff;
	assign off_clear = off_clr_ff;
	assign police_set_ones = police_ff;
	assign good_change_event = good_evt_ff;
	assign on_change_event = on_evt_ff;
	assign cooldown_cancel = cool_ff;
	assign channel_power_state = {pg_ff, pe_ff};
	assign channel_mode_select = mode_ff;

	sequence s_read(logic [7:0] code);
		req_edge && addr_hit && !xif.wr && (xif.cmd == code);
	endsequence

	sequence s_enter_off;
		wr_mode && (|entry);
	endsequence

	property p_status_read;
		@(posedge clock) disable iff (rst)
		s_read(CMD_POWER_STATE) |=> rdata_ff == $past({pg_ff, pe_ff});
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("power state readback wrong");

	property p_off_drops_flags;
		@(posedge clock) disable iff (rst)
		s_enter_off |=> ((pe_ff | pg_ff) & $past(entry)) == 4'h0 ##1
			((pe_ff | pg_ff) & $past(entry, 2)) == 4'h0;
	endproperty
	a_off_drops_flags: assert property (p_off_drops_flags)
		else $error("flags survive entry to off");

	property p_pg_hold;
		@(posedge clock) disable iff (rst)
		((($past(pg_ff) & $past(chan_on_in) & ~$past(off_now)) & ~pg_ff)
			== 4'h0) && ((pg_ff & ~pe_ff) == 4'h0);
	endproperty
	a_pg_hold: assert property (p_pg_hold)
		else $error("power good lost while on or set while off");

	property p_strap_read;
		@(posedge clock) disable iff (rst)
		s_read(CMD_STRAP) |=> rdata_ff[6:3] == $past(strap_ff) &&
			(!$past(cfg_b_ff) || !rdata_ff[2]) && rdata_ff[7] == 1'b0 &&
			rdata_ff[1:0] == 2'h0;
	endproperty
	a_strap_read: assert property (p_strap_read)
		else $error("strap readback wrong");

	property p_bcast_hit;
		@(posedge clock) disable iff (rst)
		(req_edge && xif.addr == ADDR_BCAST) |=> hit_ff ##1 xif.ack_tgl ==
			$past(xif.ack_tgl);
	endproperty
	a_bcast_hit: assert property (p_bcast_hit)
		else $error("broadcast address not answered");

	property p_mode_write;
		@(posedge clock) disable iff (rst)
		wr_mode |=> channel_mode_select == $past(xif.wdata) ##1
			(wr_mode || $stable(channel_mode_select));
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode register write not held");

	property p_off_gates;
		@(posedge clock) disable iff (rst)
		((power_allow | detect_enable_out | class_enable_out | power_on_out)
			& pcms_off_mask($past(nxt_mode))) == 4'h0;
	endproperty
	a_off_gates: assert property (p_off_gates)
		else $error("off channel still enabled");

	property p_clear_strobe;
		@(posedge clock) disable iff (rst)
		s_enter_off |=> (off_clear == police_set_ones) &&
			(off_clear == (pcms_off_mask(mode_ff) &
			~pcms_off_mask($past(mode_ff))));
	endproperty
	a_clear_strobe: assert property (p_clear_strobe)
		else $error("off strobe hits wrong channels");

	property p_fall_event;
		@(posedge clock) disable iff (rst)
		(on_change_event == ($past(pe_ff) & ~pe_ff)) &&
			(good_change_event == ($past(pg_ff) & ~pg_ff));
	endproperty
	a_fall_event: assert property (p_fall_event)
		else $error("change event does not match flag fall");

	property p_cool;
		@(posedge clock) disable iff (rst)
		(wr_mode && pcms_mode_of(mode_ff, 2) == MODE_SEMI &&
			xif.wdata[5] == 1'b0) |=> cooldown_cancel[2] ##1
			!cooldown_cancel[2];
	endproperty
	a_cool: assert property (p_cool)
		else $error("cooldown not cancelled on leaving semiauto");
endmodule : pcms_top

// ---- design/pcms_xfer_if.sv ----
// Request and answer signals between the link end and the register core
`timescale 1ns/1ps
interface pcms_xfer_if;
	logic req_tgl;
	logic [6:0] addr;
	logic [7:0] cmd;
	logic wr;
	logic [7:0] wdata;
	logic ack_tgl;
	logic hit;
	logic [7:0] rdata;

	modport link (
		output req_tgl,
		output addr,
		output cmd,
		output wr,
		output wdata,
		input ack_tgl,
		input hit,
		input rdata
	);
	modport core (
		input req_tgl,
		input addr,
		input cmd,
		input wr,
		input wdata,
		output ack_tgl,
		output hit,
		output rdata
	);
endinterface : pcms_xfer_if
